//--- verilog/reclose_pkg.sv
package reclose_pkg;
	// Clock period and the common sequence tick, both in nanoseconds.
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned TICK_PERIOD_NS = 10_000_000;
	localparam int unsigned TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
	// Ticks in one minute for the operations window and recovery time.
	localparam int unsigned MINUTE_MS = 60_000;
	localparam int unsigned TICK_MS = TICK_PERIOD_NS / 1_000_000;
	localparam int unsigned MINUTE_TICKS = MINUTE_MS / TICK_MS;
	// Widths of settings and counters, and the shot, pin and term counts.
	localparam int unsigned TIME_W = 17;
	localparam int unsigned MIN_W = 8;
	localparam int unsigned CUM_W = 10;
	localparam int unsigned OPS_W = 8;
	localparam int unsigned SHOT_W = 3;
	localparam int unsigned MAX_SHOTS = 4;
	localparam int unsigned NUM_PIN = 4;
	localparam int unsigned TERMS = 2;
	localparam int unsigned TERM_W = 2 * NUM_PIN;
	// Values after reset.
	localparam logic [TIME_W-1:0] TIME_RST = 17'h00000;
	localparam logic [CUM_W-1:0] CUM_RST = 10'h000;
	localparam logic [15:0] OPS_SUM_RST = 16'h0000;

	typedef enum logic [2:0] {
		ST_DISABLED,
		ST_READY,
		ST_DEAD,
		ST_CLOSING,
		ST_RESET,
		ST_LOCKOUT
	} seq_state_t;
endpackage

//--- verilog/breaker_reclose_sequencer.sv
`timescale 1ns/1ps
module breaker_reclose_sequencer
	import reclose_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF,
	parameter int unsigned NUM_OUT = 2
) (
	// Clock and reset.
	input  wire logic                      CLK,
	input  wire logic                      ARST_N,
	// Field pins, asynchronous.
	input  wire logic                      BREAKER_AUX_B_CONTACT,
	input  wire logic                      RECLOSE_INIT,
	input  wire logic                      FREEZE,
	input  wire logic                      MANUAL_CLOSE,
	input  wire logic                      SUPERVISION_OK,
	input  wire logic [NUM_PIN-1:0]        PROG_PIN,
	// Sequence settings.
	input  wire logic                      UNIT_ENABLE,
	input  wire logic [SHOT_W-1:0]         SHOTS,
	input  wire logic [TIME_W-1:0]         DEAD_TIME,
	input  wire logic [TIME_W-1:0]         RESET_TIME,
	input  wire logic                      FREEZE_ENABLE,
	input  wire logic                      MAX_CYCLE_ENABLE,
	input  wire logic [TIME_W-1:0]         MAX_TIME,
	input  wire logic                      FOLLOW_ENABLE,
	input  wire logic                      CUM_ENABLE,
	input  wire logic [CUM_W-1:0]          CUM_LIMIT,
	input  wire logic                      OPERATIONS_LIMIT_ENABLE,
	input  wire logic [OPS_W-1:0]          OPS_MAX_COUNT,
	input  wire logic [MIN_W-1:0]          OPS_DURATION,
	input  wire logic [MIN_W-1:0]          OPS_RECOVERY,
	input  wire logic                      MANUAL_CLOSE_ENABLE,
	input  wire logic                      MANUAL_SUPERVISE,
	// Programmable output settings, packed per output.
	input  wire logic                      PROG_ENABLE,
	input  wire logic [NUM_OUT*TERMS*TERM_W-1:0] OUT_EQUATION,
	input  wire logic [NUM_OUT*TIME_W-1:0] OUTPUT_PICKUP_DELAY,
	input  wire logic [NUM_OUT*TIME_W-1:0] OUTPUT_DROPOUT_DELAY,
	input  wire logic [NUM_OUT-1:0]        OUT_ENABLE,
	// Remote settings and clock writes.
	input  wire logic                      REMOTE_ENABLE,
	input  wire logic                      REMOTE_REQ,
	input  wire logic                      REMOTE_PASSWORD_OK,
	input  wire logic                      TIME_SET_ENABLE,
	input  wire logic                      TIME_WR,
	input  wire logic [39:0]               TIME_WDATA,
	// Status and drive outputs.
	output logic                           CLOSE_OUT,
	output logic                           READY,
	output logic                           IN_PROGRESS,
	output logic                           LOCKOUT,
	output logic                           OPS_LOCKOUT,
	output logic [SHOT_W-1:0]              SHOT_NUM,
	output logic                           MAINT_ALARM,
	output logic                           MAINT_MESSAGE,
	output logic [NUM_OUT-1:0]             PROG_OUT,
	output logic                           REMOTE_ACCEPT,
	output logic                           REMOTE_REJECT,
	output logic [39:0]                    CLOCK_FIELDS
);
	// Refuse parameter values that the divider or outputs cannot serve.
	if (TICK_CYCLES < 1 || NUM_OUT < 1 || NUM_OUT > 8) begin : bad_param
		$error("breaker_reclose_sequencer: bad parameter");
	end

	localparam int unsigned TICK_W = $clog2(TICK_CYCLES + 1);
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
	localparam logic [12:0] MIN_LAST = 13'(MINUTE_TICKS - 1);

	// Sum-of-products match: a term hits when all its masked pins agree; an empty mask never hits.
	function automatic logic term_hit(input logic [TERM_W-1:0] t,
			input logic [NUM_PIN-1:0] pins);
		logic [NUM_PIN-1:0] mask;
		logic [NUM_PIN-1:0] pol;
		mask = t[TERM_W-1:NUM_PIN];
		pol = t[NUM_PIN-1:0];
		term_hit = (mask != '0) && (((pins ^ ~pol) & mask) == mask);
	endfunction

	// Two-stage synchronisers for every pin input.
	logic [NUM_PIN+4:0] sync1_reg;
	logic [NUM_PIN+4:0] sync2_reg;
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= {PROG_PIN, SUPERVISION_OK, MANUAL_CLOSE, FREEZE,
				RECLOSE_INIT, BREAKER_AUX_B_CONTACT};
			sync2_reg <= sync1_reg;
		end
	end

	// The auxiliary b contact is closed while the breaker is open.
	logic brk_open;
	logic manual_req;
	logic freeze_in;
	logic supv_ok;
	logic [NUM_PIN-1:0] pins;
	assign brk_open = sync2_reg[0];
	assign freeze_in = sync2_reg[2];
	assign manual_req = sync2_reg[3];
	assign supv_ok = sync2_reg[4];
	assign pins = sync2_reg[NUM_PIN+4:5];

	// One common tick; the sequence copy stops under freeze.
	logic [TICK_W-1:0] div_reg;
	logic tick_reg;
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			div_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			tick_reg <= (div_reg == TICK_LAST);
			div_reg <= (div_reg == TICK_LAST) ? '0 : div_reg + 1'b1;
		end
	end
	logic seq_tick;
	assign seq_tick = tick_reg && !(FREEZE_ENABLE && freeze_in);

	// Minute strobe for the operations window, not frozen.
	logic [12:0] min_div_reg;
	logic minute;
	assign minute = tick_reg && (min_div_reg == MIN_LAST);
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			min_div_reg <= '0;
		end else if (tick_reg) begin
			min_div_reg <= minute ? '0 : min_div_reg + 1'b1;
		end
	end

	seq_state_t state_reg;
	seq_state_t state_next;
	logic [TIME_W-1:0] timer_reg;
	logic [TIME_W-1:0] cycle_reg;
	logic [SHOT_W-1:0] shot_reg;
	logic ops_lock_reg;
	logic [MIN_W-1:0] recov_reg;
	logic [15:0] ops_sum_reg;
	logic timer_done;
	logic cycle_over;
	logic ops_over;
	logic reclose_evt;
	assign timer_done = seq_tick && (timer_reg == '0);
	assign cycle_over = MAX_CYCLE_ENABLE && brk_open
		&& (cycle_reg >= MAX_TIME);
	assign ops_over = OPERATIONS_LIMIT_ENABLE
		&& (ops_sum_reg > 16'(OPS_MAX_COUNT));
	assign reclose_evt = (state_reg == ST_CLOSING) && !brk_open;

	// Sequencer next state.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_DISABLED: begin
				state_next = ST_READY;
			end
			ST_READY: begin
				if (brk_open) begin
					state_next = (SHOTS == '0) ? ST_LOCKOUT : ST_DEAD;
				end
			end
			ST_DEAD: begin
				if (FOLLOW_ENABLE && !brk_open) begin
					state_next = ST_RESET;
				end else if (timer_done) begin
					state_next = ST_CLOSING;
				end
			end
			ST_CLOSING: begin
				if (!brk_open) begin
					state_next = ST_RESET;
				end
			end
			ST_RESET: begin
				if (brk_open) begin
					state_next = (shot_reg >= SHOTS) ? ST_LOCKOUT
						: ST_DEAD;
				end else if (timer_done) begin
					state_next = ST_READY;
				end
			end
			ST_LOCKOUT: begin
				if (ops_lock_reg) begin
					state_next = ST_LOCKOUT;
				end else if (MANUAL_CLOSE_ENABLE && manual_req
						&& (!MANUAL_SUPERVISE || supv_ok)) begin
					state_next = ST_CLOSING;
				end
			end
			default: begin
				state_next = ST_DISABLED;
			end
		endcase
		if (state_reg != ST_LOCKOUT && state_reg != ST_DISABLED
				&& state_reg != ST_READY && (cycle_over || ops_over)) begin
			state_next = ST_LOCKOUT;
		end
		if (state_reg == ST_READY && ops_over) begin
			state_next = ST_LOCKOUT;
		end
		if (!UNIT_ENABLE) begin
			state_next = ST_DISABLED;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_reg <= ST_DISABLED;
		end else begin
			state_reg <= state_next;
		end
	end

	// Phase timer, loaded on entry to dead time and reset phase.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			timer_reg <= TIME_RST;
		end else if (state_next == ST_DEAD && state_reg != ST_DEAD) begin
			timer_reg <= DEAD_TIME;
		end else if (state_next == ST_RESET && state_reg != ST_RESET) begin
			timer_reg <= RESET_TIME;
		end else if (seq_tick && timer_reg != '0) begin
			timer_reg <= timer_reg - 1'b1;
		end
	end

	// Sequence duration, held at zero while ready.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			cycle_reg <= TIME_RST;
		end else if (state_reg == ST_READY || state_reg == ST_DISABLED) begin
			cycle_reg <= TIME_RST;
		end else if (seq_tick && cycle_reg != '1) begin
			cycle_reg <= cycle_reg + 1'b1;
		end
	end

	// Shot number counts each entry into dead time.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			shot_reg <= '0;
		end else if (state_next == ST_READY || state_next == ST_DISABLED) begin
			shot_reg <= '0;
		end else if (state_next == ST_DEAD && state_reg != ST_DEAD) begin
			shot_reg <= shot_reg + 1'b1;
		end
	end

	// Per-minute reclosure buckets give a sliding window sum.
	logic [OPS_W-1:0] bucket_mem [256];
	logic [7:0] ptr_reg;
	logic [7:0] ptr_new;
	logic [7:0] old_idx;
	assign ptr_new = ptr_reg + 8'h01;
	assign old_idx = ptr_new - OPS_DURATION;
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			for (int i = 0; i < 256; i++) begin
				bucket_mem[i] <= '0;
			end
			ptr_reg <= 8'h00;
			ops_sum_reg <= OPS_SUM_RST;
		end else if (!OPERATIONS_LIMIT_ENABLE) begin
			ops_sum_reg <= OPS_SUM_RST;
			for (int i = 0; i < 256; i++) begin
				bucket_mem[i] <= '0;
			end
		end else if (minute) begin
			ptr_reg <= ptr_new;
			bucket_mem[ptr_new] <= OPS_W'(reclose_evt);
			ops_sum_reg <= ops_sum_reg - 16'(bucket_mem[old_idx])
				+ 16'(reclose_evt);
		end else if (reclose_evt && bucket_mem[ptr_reg] != '1) begin
			bucket_mem[ptr_reg] <= bucket_mem[ptr_reg] + 1'b1;
			ops_sum_reg <= ops_sum_reg + 16'h0001;
		end
	end

	// Recovery time after the operations limit tripped.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ops_lock_reg <= 1'b0;
			recov_reg <= '0;
		end else if (!UNIT_ENABLE) begin
			ops_lock_reg <= 1'b0;
		end else if (ops_over && state_next == ST_LOCKOUT && !ops_lock_reg) begin
			ops_lock_reg <= 1'b1;
			recov_reg <= OPS_RECOVERY;
		end else if (ops_lock_reg && minute) begin
			if (recov_reg <= 8'h01) begin
				ops_lock_reg <= 1'b0;
			end
			recov_reg <= recov_reg - 1'b1;
		end
	end

	// Cumulative reclosures; a limit change or disable restarts it.
	logic [CUM_W-1:0] cum_reg;
	logic [CUM_W-1:0] limit_seen_reg;
	logic maint_pend_reg;
	logic cum_reset;
	assign cum_reset = !CUM_ENABLE || (CUM_LIMIT != limit_seen_reg);
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			cum_reg <= CUM_RST;
			limit_seen_reg <= CUM_RST;
			maint_pend_reg <= 1'b0;
		end else begin
			limit_seen_reg <= CUM_LIMIT;
			if (cum_reset) begin
				cum_reg <= CUM_RST;
				maint_pend_reg <= 1'b0;
			end else begin
				if (reclose_evt && cum_reg != '1) begin
					cum_reg <= cum_reg + 1'b1;
				end
				if (cum_reg >= CUM_LIMIT) begin
					maint_pend_reg <= 1'b1;
				end
			end
		end
	end

	// Sequence outputs; the alarm appears on return to ready.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			CLOSE_OUT <= 1'b0;
			READY <= 1'b0;
			IN_PROGRESS <= 1'b0;
			LOCKOUT <= 1'b0;
			OPS_LOCKOUT <= 1'b0;
			SHOT_NUM <= '0;
			MAINT_ALARM <= 1'b0;
			MAINT_MESSAGE <= 1'b0;
		end else begin
			CLOSE_OUT <= (state_next == ST_CLOSING);
			READY <= (state_next == ST_READY);
			IN_PROGRESS <= (state_next == ST_DEAD || state_next == ST_CLOSING
				|| state_next == ST_RESET);
			LOCKOUT <= (state_next == ST_LOCKOUT);
			OPS_LOCKOUT <= ops_lock_reg;
			SHOT_NUM <= shot_reg;
			if (cum_reset) begin
				MAINT_ALARM <= 1'b0;
				MAINT_MESSAGE <= 1'b0;
			end else if (maint_pend_reg && state_reg == ST_READY) begin
				MAINT_ALARM <= 1'b1;
				MAINT_MESSAGE <= 1'b1;
			end
		end
	end

	// Programmable outputs with their own pickup and dropout timers.
	logic [TIME_W-1:0] pdly_reg [NUM_OUT];
	logic [NUM_OUT-1:0] pstate_reg;
	logic [NUM_OUT-1:0] eq_true;
	always_comb begin
		for (int o = 0; o < NUM_OUT; o++) begin
			eq_true[o] = 1'b0;
			for (int t = 0; t < TERMS; t++) begin
				eq_true[o] = eq_true[o] | term_hit(
					OUT_EQUATION[(o*TERMS+t)*TERM_W +: TERM_W], pins);
			end
		end
	end
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			for (int o = 0; o < NUM_OUT; o++) begin
				pdly_reg[o] <= TIME_RST;
			end
			pstate_reg <= '0;
			PROG_OUT <= '0;
		end else begin
			for (int o = 0; o < NUM_OUT; o++) begin
				if (!PROG_ENABLE) begin
					pstate_reg[o] <= 1'b0;
					pdly_reg[o] <= OUTPUT_PICKUP_DELAY[o*TIME_W +: TIME_W];
				end else if (eq_true[o] == pstate_reg[o]) begin
					// Equation agrees with output: rearm the opposite delay.
					pdly_reg[o] <= pstate_reg[o]
						? OUTPUT_DROPOUT_DELAY[o*TIME_W +: TIME_W]
						: OUTPUT_PICKUP_DELAY[o*TIME_W +: TIME_W];
				end else if (tick_reg) begin
					if (pdly_reg[o] <= 17'h00001) begin
						pstate_reg[o] <= eq_true[o];
					end else begin
						pdly_reg[o] <= pdly_reg[o] - 1'b1;
					end
				end
			end
			PROG_OUT <= pstate_reg & OUT_ENABLE
				& {NUM_OUT{PROG_ENABLE}};
		end
	end

	// Remote setting requests and real time clock writes.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			REMOTE_ACCEPT <= 1'b0;
			REMOTE_REJECT <= 1'b0;
			CLOCK_FIELDS <= '0;
		end else begin
			REMOTE_ACCEPT <= REMOTE_REQ && REMOTE_ENABLE
				&& REMOTE_PASSWORD_OK;
			REMOTE_REJECT <= REMOTE_REQ
				&& !(REMOTE_ENABLE && REMOTE_PASSWORD_OK);
			if (TIME_WR && TIME_SET_ENABLE) begin
				CLOCK_FIELDS <= TIME_WDATA;
			end
		end
	end
endmodule

//--- dv/breaker_model.sv
`timescale 1ns/1ps
module breaker_model #(
	parameter int CLOSE_DLY = 3
) (
	// Clock.
	input  wire logic clk,
	// Commands from the relay and the bench.
	input  wire logic close_cmd,
	input  wire logic trip,
	input  wire logic ext_close,
	input  wire logic slow,
	// Auxiliary contact, high while the breaker is open.
	output logic      aux_b
);
	int cnt = 0;

	initial aux_b = 1'b0;

	// The mechanism closes after the command has been held a while, or at once on ext_close.
	always @(posedge clk) begin
		if (trip)
			aux_b <= 1'b1;
		else if (ext_close || cnt >= (slow ? 4 * CLOSE_DLY : CLOSE_DLY))
			aux_b <= 1'b0;
		cnt <= (close_cmd && aux_b) ? cnt + 1 : 0;
	end
endmodule

//--- dv/reclose_sva.sv
`timescale 1ns/1ps
module reclose_sva #(
	parameter int unsigned NUM_OUT = 2
) (
	// Clock and reset.
	input wire logic               CLK,
	input wire logic               ARST_N,
	// Watched inputs.
	input wire logic               BREAKER_AUX_B_CONTACT,
	input wire logic               UNIT_ENABLE,
	input wire logic               MAX_CYCLE_ENABLE,
	input wire logic               CUM_ENABLE,
	input wire logic               PROG_ENABLE,
	input wire logic [NUM_OUT-1:0] OUT_ENABLE,
	input wire logic               REMOTE_ENABLE,
	input wire logic               REMOTE_REQ,
	input wire logic               REMOTE_PASSWORD_OK,
	input wire logic               TIME_SET_ENABLE,
	input wire logic               TIME_WR,
	input wire logic [39:0]        TIME_WDATA,
	// Watched outputs.
	input wire logic               CLOSE_OUT,
	input wire logic               READY,
	input wire logic               IN_PROGRESS,
	input wire logic               LOCKOUT,
	input wire logic               OPS_LOCKOUT,
	input wire logic               MAINT_ALARM,
	input wire logic               MAINT_MESSAGE,
	input wire logic [NUM_OUT-1:0] PROG_OUT,
	input wire logic               REMOTE_ACCEPT,
	input wire logic               REMOTE_REJECT,
	input wire logic [39:0]        CLOCK_FIELDS
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);

	// Level settings get three edges, covering the state and output stages.
	chk_ready_excl: assert property (
		READY |-> !IN_PROGRESS && !LOCKOUT && !CLOSE_OUT)
		else $error("ready overlaps sequence state");
	chk_unit_off: assert property (
		!UNIT_ENABLE [*3] |-> !READY && !IN_PROGRESS && !CLOSE_OUT && !LOCKOUT)
		else $error("sequence active while unit disabled");
	chk_close_hold: assert property (
		(BREAKER_AUX_B_CONTACT && UNIT_ENABLE && !MAX_CYCLE_ENABLE) [*3]
		##0 CLOSE_OUT |=> CLOSE_OUT)
		else $error("close released with breaker open");
	chk_remote_resp: assert property (
		REMOTE_REQ |=> REMOTE_REJECT == !REMOTE_ACCEPT && REMOTE_ACCEPT
		== ($past(REMOTE_ENABLE) && $past(REMOTE_PASSWORD_OK)))
		else $error("remote answer wrong");
	chk_remote_idle: assert property (
		!REMOTE_REQ |=> !REMOTE_ACCEPT && !REMOTE_REJECT)
		else $error("remote answer without request");
	chk_time_wr: assert property (
		TIME_WR && TIME_SET_ENABLE |=> CLOCK_FIELDS == $past(TIME_WDATA))
		else $error("clock write lost");
	chk_time_hold: assert property (
		(!TIME_WR || !TIME_SET_ENABLE) |=> $stable(CLOCK_FIELDS))
		else $error("clock changed without enabled write");
	chk_prog_gate: assert property (
		!PROG_ENABLE [*3] |-> PROG_OUT == '0)
		else $error("output active with global enable off");
	chk_out_gate: assert property (
		(PROG_OUT & ~$past(OUT_ENABLE)) == '0)
		else $error("output active with its enable off");
	chk_maint_off: assert property (
		!CUM_ENABLE [*3] |-> !MAINT_ALARM && !MAINT_MESSAGE)
		else $error("maintenance alarm with count disabled");
	chk_ops_lock: assert property (
		OPS_LOCKOUT |-> LOCKOUT && !CLOSE_OUT && !READY)
		else $error("operations lockout left early");

	cov_close: cover property ($rose(CLOSE_OUT));
	cov_lock: cover property ($rose(LOCKOUT));
	cov_maint: cover property ($rose(MAINT_ALARM));
	cov_prog: cover property ($rose(PROG_OUT[0]));
endmodule

//--- dv/testbench.sv
`timescale 1ns/1ps
module testbench;
	import reclose_pkg::*;
	localparam int TC = 4;
	localparam int DT = 3;
	localparam int RT = 5;
	localparam int LIMIT = 40000;
	// Inputs of the design and of the breaker model.
	logic CLK, ARST_N, RECLOSE_INIT, FREEZE, MANUAL_CLOSE, SUPERVISION_OK;
	logic UNIT_ENABLE, FREEZE_ENABLE, MAX_CYCLE_ENABLE, FOLLOW_ENABLE;
	logic CUM_ENABLE, OPERATIONS_LIMIT_ENABLE, MANUAL_CLOSE_ENABLE;
	logic MANUAL_SUPERVISE, PROG_ENABLE, REMOTE_ENABLE, REMOTE_REQ;
	logic REMOTE_PASSWORD_OK, TIME_SET_ENABLE, TIME_WR;
	logic trip, ext_close, slow;
	logic [NUM_PIN-1:0] PROG_PIN;
	logic [SHOT_W-1:0] SHOTS, SHOT_NUM;
	logic [TIME_W-1:0] DEAD_TIME, RESET_TIME, MAX_TIME;
	logic [CUM_W-1:0] CUM_LIMIT;
	logic [OPS_W-1:0] OPS_MAX_COUNT;
	logic [MIN_W-1:0] OPS_DURATION, OPS_RECOVERY;
	logic [2*TERMS*TERM_W-1:0] OUT_EQUATION;
	logic [2*TIME_W-1:0] OUTPUT_PICKUP_DELAY, OUTPUT_DROPOUT_DELAY;
	logic [1:0] OUT_ENABLE, PROG_OUT;
	logic [39:0] TIME_WDATA, CLOCK_FIELDS;
	// Outputs of the design and the breaker contact.
	logic CLOSE_OUT, READY, IN_PROGRESS, LOCKOUT, OPS_LOCKOUT, MAINT_ALARM;
	logic MAINT_MESSAGE, REMOTE_ACCEPT, REMOTE_REJECT, BREAKER_AUX_B_CONTACT;
	wire logic [7:0] st = {PROG_OUT, OPS_LOCKOUT, MAINT_ALARM, LOCKOUT,
		CLOSE_OUT, IN_PROGRESS, READY};
	int n_errors = 0;
	int compares = 0;
	int cyc = 0;
	int n = 0;

	breaker_reclose_sequencer #(.TICK_CYCLES(TC), .NUM_OUT(2)) uut (.*);
	breaker_model bkr (.clk(CLK), .close_cmd(CLOSE_OUT), .trip(trip),
		.ext_close(ext_close), .slow(slow), .aux_b(BREAKER_AUX_B_CONTACT));

	always #5 CLK = ~CLK;

	// A hang is cut short well beyond the longest expected run.
	always @(posedge CLK) begin
		cyc++;
		if (cyc == LIMIT) begin
			n_errors++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chkb(input logic g, input logic e);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("Error at %0t: bit %b expected %b", $time, g, e);
		end
	endtask
	task automatic chkv(input logic [39:0] g, input logic [39:0] e);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("Error at %0t: value %h expected %h", $time, g, e);
		end
	endtask
	task automatic cy(input int k);
		repeat (k) @(posedge CLK);
	endtask
	// Polls one status bit off the edge; n keeps the cycles waited.
	task automatic wt(input int b, input logic v, input int lim);
		n = 0;
		#1;
		while (st[b] !== v && n < lim) begin
			@(posedge CLK);
			#1;
			n++;
		end
		chkb(st[b], v);
	endtask
	task automatic endt(input string s);
		$display("test %s done", s);
	endtask
	task automatic pulse_trip();
		cy(1);
		trip <= 1'b1;
		cy(1);
		trip <= 1'b0;
	endtask
	task automatic shot();
		pulse_trip();
		wt(2, 1'b1, 40);
		wt(2, 1'b0, 20);
	endtask
	// Manual close out of lockout, then back to ready.
	task automatic man();
		cy(1);
		MANUAL_CLOSE <= 1'b1;
		wt(2, 1'b1, 20);
		wt(2, 1'b0, 20);
		cy(1);
		MANUAL_CLOSE <= 1'b0;
		MANUAL_SUPERVISE <= 1'b0;
		wt(0, 1'b1, 60);
	endtask

	task automatic t_ops();
		cy(1);
		OPERATIONS_LIMIT_ENABLE <= 1'b1;
		OPS_MAX_COUNT <= 8'h01;
		OPS_DURATION <= 8'h05;
		OPS_RECOVERY <= 8'h01;
		shot();
		wt(0, 1'b1, 60);
		shot();
		wt(5, 1'b1, 40);
		pulse_trip();
		MANUAL_CLOSE <= 1'b1;
		cy(20);
		#1;
		chkb(CLOSE_OUT, 1'b0);
		cy(1);
		MANUAL_CLOSE <= 1'b0;
		OPERATIONS_LIMIT_ENABLE <= 1'b0;
		wt(5, 1'b0, 6000 * TC + 200);
		chkb(n > 20000, 1'b1);
		chkb(LOCKOUT, 1'b1);
		man();
		endt("ops");
	endtask
	task automatic t_cycle();
		cy(1);
		slow <= 1'b1;
		pulse_trip();
		wt(2, 1'b1, 40);
		chkv(40'(SHOT_NUM), 40'h1);
		wt(2, 1'b0, 20);
		wt(0, 1'b1, 60);
		chkb(n >= (RT - 1) * TC && n <= (RT + 1) * TC + 8, 1'b1);
		cy(1);
		slow <= 1'b0;
		endt("cycle");
	endtask
	task automatic t_reopen();
		shot();
		cy(3);
		shot();
		chkv(40'(SHOT_NUM), 40'h2);
		cy(3);
		pulse_trip();
		wt(3, 1'b1, 20);
		cy(1);
		MANUAL_SUPERVISE <= 1'b1;
		SUPERVISION_OK <= 1'b0;
		MANUAL_CLOSE <= 1'b1;
		cy(10);
		#1;
		chkb(CLOSE_OUT, 1'b0);
		cy(1);
		SUPERVISION_OK <= 1'b1;
		man();
		endt("reopen");
	endtask
	task automatic t_freeze();
		cy(1);
		FREEZE_ENABLE <= 1'b1;
		DEAD_TIME <= 17'h00006;
		pulse_trip();
		cy(3 + 4 * TC);
		FREEZE <= 1'b1;
		cy(40);
		#1;
		chkb(CLOSE_OUT, 1'b0);
		cy(1);
		FREEZE <= 1'b0;
		wt(2, 1'b1, 40);
		chkb(n <= 3 * TC + 5, 1'b1);
		wt(2, 1'b0, 20);
		wt(0, 1'b1, 60);
		cy(1);
		FREEZE_ENABLE <= 1'b0;
		DEAD_TIME <= 17'(DT);
		endt("freeze");
	endtask
	task automatic t_max();
		cy(1);
		MAX_CYCLE_ENABLE <= 1'b1;
		MAX_TIME <= 17'h00008;
		shot();
		wt(0, 1'b1, 60);
		shot();
		wt(0, 1'b1, 60);
		cy(1);
		MAX_TIME <= 17'h00002;
		pulse_trip();
		wt(3, 1'b1, 30);
		chkb(CLOSE_OUT, 1'b0);
		cy(1);
		MAX_CYCLE_ENABLE <= 1'b0;
		man();
		cy(1);
		SHOTS <= 3'h0;
		pulse_trip();
		wt(3, 1'b1, 10);
		chkb(IN_PROGRESS, 1'b0);
		cy(1);
		SHOTS <= 3'h2;
		man();
		endt("max");
	endtask
	task automatic t_follow();
		cy(1);
		FOLLOW_ENABLE <= 1'b1;
		pulse_trip();
		cy(4);
		ext_close <= 1'b1;
		cy(1);
		ext_close <= 1'b0;
		cy(DT * TC + 4);
		#1;
		chkb(CLOSE_OUT, 1'b0);
		wt(0, 1'b1, 60);
		cy(1);
		FOLLOW_ENABLE <= 1'b0;
		endt("follow");
	endtask
	task automatic t_maint();
		cy(1);
		CUM_LIMIT <= 10'h002;
		CUM_ENABLE <= 1'b1;
		shot();
		wt(0, 1'b1, 60);
		chkb(MAINT_ALARM, 1'b0);
		shot();
		wt(0, 1'b1, 60);
		wt(4, 1'b1, 4);
		chkb(MAINT_MESSAGE, 1'b1);
		cy(10);
		#1;
		chkb(MAINT_ALARM, 1'b1);
		cy(1);
		CUM_LIMIT <= 10'h003;
		wt(4, 1'b0, 4);
		cy(1);
		CUM_ENABLE <= 1'b0;
		endt("maint");
	endtask
	task automatic t_prog();
		cy(1);
		PROG_ENABLE <= 1'b1;
		OUT_ENABLE <= 2'h3;
		PROG_PIN <= 4'h3;
		cy(4);
		#1;
		chkb(PROG_OUT[0], 1'b0);
		wt(6, 1'b1, 20);
		chkb(PROG_OUT[1], 1'b0);
		cy(1);
		PROG_PIN <= 4'h0;
		cy(6);
		#1;
		chkb(PROG_OUT[0], 1'b1);
		wt(6, 1'b0, 25);
		wt(7, 1'b1, 40);
		cy(1);
		OUT_ENABLE <= 2'h1;
		wt(7, 1'b0, 3);
		cy(1);
		OUT_ENABLE <= 2'h3;
		wt(7, 1'b1, 3);
		cy(1);
		PROG_ENABLE <= 1'b0;
		wt(7, 1'b0, 3);
		endt("prog");
	endtask
	task automatic t_rc();
		for (int i = 0; i < 4; i++) begin
			cy(1);
			{REMOTE_ENABLE, REMOTE_PASSWORD_OK} <= 2'(i);
			cy(1);
			REMOTE_REQ <= 1'b1;
			cy(1);
			REMOTE_REQ <= 1'b0;
			#1;
			chkb(REMOTE_ACCEPT, i == 3);
			chkb(REMOTE_REJECT, i != 3);
		end
		cy(1);
		TIME_WDATA <= 40'h1805_1f03_17;
		TIME_WR <= 1'b1;
		cy(1);
		TIME_WR <= 1'b0;
		cy(2);
		#1;
		chkv(CLOCK_FIELDS, 40'h0);
		cy(1);
		TIME_SET_ENABLE <= 1'b1;
		TIME_WR <= 1'b1;
		cy(1);
		TIME_WR <= 1'b0;
		cy(1);
		#1;
		chkv(CLOCK_FIELDS, 40'h1805_1f03_17);
		endt("remote_clock");
	endtask
	task automatic t_unit();
		cy(1);
		UNIT_ENABLE <= 1'b0;
		cy(4);
		#1;
		chkb(READY, 1'b0);
		pulse_trip();
		cy(2 * DT * TC);
		#1;
		chkb(CLOSE_OUT | IN_PROGRESS | LOCKOUT, 1'b0);
		cy(1);
		ext_close <= 1'b1;
		cy(1);
		ext_close <= 1'b0;
		cy(3);
		UNIT_ENABLE <= 1'b1;
		wt(0, 1'b1, 20);
		cy(4);
		#1;
		chkb(READY, 1'b1);
		endt("unit");
	endtask

	// Settings start quiet; reset is held for six cycles.
	initial begin
		CLK = 1'b0;
		ARST_N = 1'b0;
		{RECLOSE_INIT, FREEZE, MANUAL_CLOSE, FREEZE_ENABLE, MAX_CYCLE_ENABLE,
			FOLLOW_ENABLE, CUM_ENABLE, OPERATIONS_LIMIT_ENABLE, MANUAL_SUPERVISE,
			PROG_ENABLE, REMOTE_ENABLE, REMOTE_REQ, REMOTE_PASSWORD_OK,
			TIME_SET_ENABLE, TIME_WR, trip, ext_close, slow, PROG_PIN,
			OUT_ENABLE, CUM_LIMIT, OPS_MAX_COUNT, OPS_DURATION, OPS_RECOVERY,
			TIME_WDATA, MAX_TIME} = '0;
		{SUPERVISION_OK, UNIT_ENABLE, MANUAL_CLOSE_ENABLE} = 3'h7;
		SHOTS = 3'h2;
		DEAD_TIME = 17'(DT);
		RESET_TIME = 17'(RT);
		OUT_EQUATION = 32'h0040_0033;
		OUTPUT_PICKUP_DELAY = {17'h00005, 17'h00002};
		OUTPUT_DROPOUT_DELAY = {17'h00001, 17'h00003};
		cy(6);
		ARST_N <= 1'b1;
		wt(0, 1'b1, 10);
		chkv(CLOCK_FIELDS, 40'h0);
		t_ops();
		t_cycle();
		t_reopen();
		t_freeze();
		t_max();
		t_follow();
		t_maint();
		t_prog();
		t_rc();
		t_unit();
		print_verdict();
	end
endmodule

bind breaker_reclose_sequencer reclose_sva #(.NUM_OUT(NUM_OUT)) chk (.*);
